// ==== rtl/eii_pkg.sv ====
// eii_pkg: constants for the external interrupt input block
// assumes a 125 MHz core clock; one machine cycle is six core clocks
package eii_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CLKS_PER_MCYCLE = 6;
  localparam logic [2:0] PHASE_LAST = 3'(CLKS_PER_MCYCLE - 1);
  localparam logic [2:0] PHASE_RESET = 3'h0;
  localparam logic PIN_RESET = 1'h1;
  localparam logic TRIG_LEVEL = 1'h0;
  localparam logic TRIG_EDGE = 1'h1;
  // least stable time of a pin level, in core clocks
  localparam int unsigned PIN_HOLD_CLKS = 6;
endpackage

// ==== rtl/eii_ext_irq.sv ====
// eii_ext_irq: external interrupt request pin detector with wake output
// assumes ext_request_pin is asynchronous; cpu strobes come from clk_sys logic
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - trigger bit 0: low level on pin raises the request
// - trigger bit 1: request becomes edge triggered
// - edge mode: high sample then low sample sets the flag
// - pin sampled once per machine cycle
// - edge mode: flag cleared when cpu vectors to the handler
// - level mode: still-low pin after handler gives another interrupt
// - level mode: flag follows the pin, no software clear
// - enabled request wakes processor from idle or power down
// - power down wake needs enable and priority above current service
module eii_ext_irq (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ext_request_pin,
  input wire logic trigger_type_select,
  input wire logic irqEnable,
  input wire logic priorityAbove,
  input wire logic idleMode,
  input wire logic powerDownMode,
  input wire logic vectorAck,
  input wire logic flagClearWr,
  output logic ext_request_flag,
  output logic wakeUp
);
  typedef struct packed {
    logic pinMeta;
    logic pinSync;
    logic [2:0] phase;
    logic sampleNow;
    logic flag;
    logic wake;
  } eii_state_t;

  eii_state_t st;
  eii_state_t next_st;
  logic fallSeen;
  logic edgeMode;
  logic clearReq;

  always_comb begin
    next_st = st;
    fallSeen = 1'h0;
    edgeMode = (trigger_type_select == eii_pkg::TRIG_EDGE);
    clearReq = vectorAck | flagClearWr;
    next_st.pinMeta = ext_request_pin;
    next_st.pinSync = st.pinMeta;
    // machine cycle phase counter
    if (st.phase == eii_pkg::PHASE_LAST) begin
      next_st.phase = eii_pkg::PHASE_RESET;
      next_st.sampleNow = st.pinSync;
      fallSeen = st.sampleNow & ~st.pinSync;
    end else begin
      next_st.phase = st.phase + 3'h1;
    end
    if (edgeMode) begin
      // set wins over clear
      if (fallSeen) begin
        next_st.flag = 1'h1;
      end else if (clearReq) begin
        next_st.flag = 1'h0;
      end
    end else begin
      // flag tracks sampled pin; stays while low so handler re-enters
      next_st.flag = ~next_st.sampleNow;
    end
    next_st.wake = next_st.flag & irqEnable & (idleMode |
      (powerDownMode & priorityAbove));
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '{
        pinMeta: eii_pkg::PIN_RESET,
        pinSync: eii_pkg::PIN_RESET,
        phase: eii_pkg::PHASE_RESET,
        sampleNow: eii_pkg::PIN_RESET,
        flag: 1'h0,
        wake: 1'h0
      };
    end else begin
      st <= next_st;
    end
  end

  assign ext_request_flag = st.flag;
  assign wakeUp = st.wake;

  // sync chain and sampling
  a_sync_low: assert property (@(posedge clk_sys) disable iff (reset)
    !st.pinMeta |=> !st.pinSync)
    else $error("sync chain lost a low level");

  a_sync_high: assert property (@(posedge clk_sys) disable iff (reset)
    st.pinMeta |=> st.pinSync)
    else $error("sync chain lost a high level");

  a_phase_range: assert property (@(posedge clk_sys) disable iff (reset)
    st.phase <= eii_pkg::PHASE_LAST)
    else $error("phase counter out of range");

  a_phase_step: assert property (@(posedge clk_sys) disable iff (reset)
    (st.phase != eii_pkg::PHASE_LAST) |=> (st.phase == 3'($past(st.phase) + 3'h1)))
    else $error("phase counter skipped a step");

  a_sample_rate: assert property (@(posedge clk_sys) disable iff (reset)
    (st.phase == eii_pkg::PHASE_LAST) |=> (st.phase == eii_pkg::PHASE_RESET)
    ##5 (st.phase == eii_pkg::PHASE_LAST))
    else $error("sampling not once per machine cycle");

  a_sample_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (st.phase != eii_pkg::PHASE_LAST) |=> $stable(st.sampleNow))
    else $error("pin sample changed mid machine cycle");

  a_sample_high: assert property (@(posedge clk_sys) disable iff (reset)
    (st.phase == eii_pkg::PHASE_LAST) && st.pinSync |=> st.sampleNow)
    else $error("high pin not taken at sample point");

  a_sample_low: assert property (@(posedge clk_sys) disable iff (reset)
    (st.phase == eii_pkg::PHASE_LAST) && !st.pinSync |=> !st.sampleNow)
    else $error("low pin not taken at sample point");

  a_fall_latency: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(st.pinSync) |-> ##[1:6] !st.sampleNow)
    else $error("low level not sampled within a machine cycle");

  a_rise_latency: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(st.pinSync) |-> ##[1:6] st.sampleNow)
    else $error("high level not sampled within a machine cycle");

  // level mode
  a_level_track: assert property (@(posedge clk_sys) disable iff (reset)
    (trigger_type_select == eii_pkg::TRIG_LEVEL) && $stable(trigger_type_select)
    |=> (st.flag == ~st.sampleNow))
    else $error("level flag not following sampled pin");

  a_level_low_sets: assert property (@(posedge clk_sys) disable iff (reset)
    (st.phase == eii_pkg::PHASE_LAST) && !st.pinSync
    && (trigger_type_select == eii_pkg::TRIG_LEVEL) ##1
    (trigger_type_select == eii_pkg::TRIG_LEVEL) |-> st.flag)
    else $error("low level did not raise request");

  a_level_high_clr: assert property (@(posedge clk_sys) disable iff (reset)
    (st.phase == eii_pkg::PHASE_LAST) && st.pinSync
    && (trigger_type_select == eii_pkg::TRIG_LEVEL) ##1
    (trigger_type_select == eii_pkg::TRIG_LEVEL) |-> !st.flag)
    else $error("high level did not drop request");

  a_level_steady: assert property (@(posedge clk_sys) disable iff (reset)
    (trigger_type_select == eii_pkg::TRIG_LEVEL) ##1
    (trigger_type_select == eii_pkg::TRIG_LEVEL) && (st.phase != eii_pkg::PHASE_LAST)
    |=> $stable(st.flag))
    else $error("level flag moved between samples");

  // edge mode
  a_edge_sets: assert property (@(posedge clk_sys) disable iff (reset)
    (st.phase == eii_pkg::PHASE_LAST) && st.sampleNow && !st.pinSync
    && (trigger_type_select == eii_pkg::TRIG_EDGE) |=> st.flag)
    else $error("falling edge did not set flag");

  a_edge_vector_clr: assert property (@(posedge clk_sys) disable iff (reset)
    (trigger_type_select == eii_pkg::TRIG_EDGE) && vectorAck
    && !(st.phase == eii_pkg::PHASE_LAST && st.sampleNow && !st.pinSync) |=> !st.flag)
    else $error("vectoring did not clear edge flag");

  a_edge_sw_clr: assert property (@(posedge clk_sys) disable iff (reset)
    (trigger_type_select == eii_pkg::TRIG_EDGE) && flagClearWr
    && !(st.phase == eii_pkg::PHASE_LAST && st.sampleNow && !st.pinSync) |=> !st.flag)
    else $error("software write did not clear edge flag");

  a_edge_sticky: assert property (@(posedge clk_sys) disable iff (reset)
    (trigger_type_select == eii_pkg::TRIG_EDGE) && st.flag && !vectorAck
    && !flagClearWr |=> st.flag)
    else $error("edge flag dropped without clear");

  a_edge_no_spur: assert property (@(posedge clk_sys) disable iff (reset)
    (trigger_type_select == eii_pkg::TRIG_EDGE) && !st.flag
    && !(st.phase == eii_pkg::PHASE_LAST && st.sampleNow && !st.pinSync) |=> !st.flag)
    else $error("edge flag set without falling edge");

  a_edge_mode_entry: assert property (@(posedge clk_sys) disable iff (reset)
    (trigger_type_select == eii_pkg::TRIG_LEVEL) ##1
    (trigger_type_select == eii_pkg::TRIG_EDGE) && !vectorAck && !flagClearWr
    && (st.phase != eii_pkg::PHASE_LAST) |=> $stable(st.flag))
    else $error("mode switch moved the request flag");

  // wake
  a_wake_idle: assert property (@(posedge clk_sys) disable iff (reset)
    st.flag && irqEnable && idleMode ##1 st.flag |-> wakeUp)
    else $error("enabled request did not wake from idle");

  a_wake_idle_only: assert property (@(posedge clk_sys) disable iff (reset)
    st.flag && irqEnable && idleMode && !priorityAbove ##1 st.flag |-> wakeUp)
    else $error("idle wake held back by priority");

  a_wake_pd_prio: assert property (@(posedge clk_sys) disable iff (reset)
    !idleMode && !priorityAbove |=> !wakeUp)
    else $error("power down wake without priority");

  a_wake_pd: assert property (@(posedge clk_sys) disable iff (reset)
    st.flag && irqEnable && powerDownMode && priorityAbove ##1 st.flag |-> wakeUp)
    else $error("enabled request did not wake from power down");

  a_wake_has_flag: assert property (@(posedge clk_sys) disable iff (reset)
    wakeUp |-> st.flag)
    else $error("wake raised without a pending request");

  a_wake_needs_en: assert property (@(posedge clk_sys) disable iff (reset)
    !irqEnable |=> !wakeUp)
    else $error("wake raised while interrupt disabled");

  a_wake_no_mode: assert property (@(posedge clk_sys) disable iff (reset)
    !idleMode && !powerDownMode |=> !wakeUp)
    else $error("wake raised outside idle and power down");
endmodule
`default_nettype wire

// ==== dv/eii_source_model.sv ====
// eii_source_model: request source driving the pin
// assumes drive changes on falling clock edges
`timescale 1ns/1ps
`default_nettype none
module eii_source_model (
  input wire logic clk_sys,
  output var logic pin
);
  initial pin = 1'h1;
  // holds each level n clocks, callers use 1 to 12
  task automatic drive(input logic lvl, input int n);
    pin = lvl;
    repeat (n) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// testbench: level, edge and wake scenarios
// assumes a 125 MHz clock and the pin source model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'h0, reset = 1'h1, trig = 1'h0, en = 1'h1, pri = 1'h0;
  logic idl = 1'h0, pd = 1'h0, vack = 1'h0, fclr = 1'h0, pin, flag, wake;
  int err_count = 0, comparisons = 0;
  always #4 clk_sys = ~clk_sys;
  eii_source_model src (.clk_sys(clk_sys), .pin(pin));
  eii_ext_irq u_eii_ext_irq (.clk_sys(clk_sys), .reset(reset), .ext_request_pin(pin),
    .trigger_type_select(trig), .irqEnable(en), .priorityAbove(pri), .idleMode(idl),
    .powerDownMode(pd), .vectorAck(vack), .flagClearWr(fclr),
    .ext_request_flag(flag), .wakeUp(wake));
  task automatic finish_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %b exp %b", $time, seen, exp);
    end
  endtask
  task automatic wf(input logic v);
    int i;
    for (i = 0; i < 12 && flag !== v; i++) @(negedge clk_sys);
    if (flag !== v) begin
      err_count++;
      $display("mismatch at %0t: flag wait timed out", $time);
      finish_test();
    end
  endtask
  task automatic t_level();
    src.drive(1'h0, 1);
    wf(1'h1);
    chk(flag, 1'h1);
    vack = 1'h1;
    src.drive(1'h0, 1);
    vack = 1'h0;
    src.drive(1'h0, 12);
    chk(flag, 1'h1);
    pd = 1'h1;
    src.drive(1'h0, 2);
    chk(wake, 1'h0);
    pri = 1'h1;
    src.drive(1'h0, 2);
    chk(wake, 1'h1);
    en = 1'h0;
    src.drive(1'h0, 2);
    chk(wake, 1'h0);
    en = 1'h1;
    pd = 1'h0;
    src.drive(1'h1, 1);
    wf(1'h0);
    chk(flag, 1'h0);
    $display("level test done");
  endtask
  task automatic t_edge();
    trig = 1'h1;
    idl = 1'h1;
    pri = 1'h0;
    for (int k = 0; k < 2; k++) begin
      src.drive(1'h1, 12);
      src.drive(1'h0, 12);
      wf(1'h1);
      chk(flag, 1'h1);
      chk(wake, 1'h1);
      src.drive(1'h1, 12);
      chk(flag, 1'h1);
      {fclr, vack} = (k == 0) ? 2'h1 : 2'h2;
      @(negedge clk_sys);
      {fclr, vack} = 2'h0;
      chk(flag, 1'h0);
    end
    $display("edge test done");
  endtask
  task automatic t_reset();
    src.drive(1'h0, 12);
    wf(1'h1);
    reset = 1'h1;
    src.drive(1'h1, 12);
    chk(flag, 1'h0);
    chk(wake, 1'h0);
    reset = 1'h0;
    src.drive(1'h1, 12);
    chk(flag, 1'h0);
    $display("reset test done");
  endtask
  initial begin
    repeat (3) @(negedge clk_sys);
    reset = 1'h0;
    t_level();
    t_edge();
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire
